// File: hw/change_detect.v
// Purpose: mismatch detector for the upper four keypad pins
// Assumes: pin levels synchronous to clk_in
// Notes: reference reloads on every port access
`timescale 1ns/1ns
`default_nettype none
module change_detect (
   input wire clk_in,
   input wire sys_rst_in,
   input wire [3:0] pins_in,
   input wire [3:0] dir_in,
   input wire refresh_in,
   output wire mismatch_out
);
   reg [3:0] ref_val;
   wire [3:0] diff;
   genvar i;
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ref_val <= 4'h0;
      end else if (refresh_in) begin
         ref_val <= pins_in;
      end
   end
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_cmp
         assign diff[i] = dir_in[i] & (pins_in[i] ^ ref_val[i]);
      end
   endgenerate
   assign mismatch_out = |diff;
endmodule
`default_nettype wire

// File: hw/keypad_port.v
// Purpose: 8-bit bidirectional keypad port with change interrupt, APB slave
// Assumes: pins synchronous to clk_in; zero-wait APB
// Notes: pin output enable is active low
// Behaviour
// - Eight pins, latch and direction bits
// - Direction one releases the pin
// - Direction zero drives the latch
// - Direction resets to all ones
// - Pull-up bit low enables pull-ups
// - Output pins lose their pull-up
// - Option resets to all ones
// - Upper four input pins compared only
// - Compare against pin levels at last port read or write
// - ORed mismatches set change flag
// - Change interrupt can wake sleep
// - Port access ends mismatch
// - Persistent mismatch keeps setting flag
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "keypad_port_consts.vh"
module keypad_port (
   input wire clk_in,
   input wire sys_rst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [31:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [3:0] pstrb_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   input wire [7:0] pin_in,
   output reg [7:0] pin_out,
   output reg [7:0] pin_oe_n_out,
   output reg [7:0] pullup_en_out,
   output wire change_irq_out,
   output wire wake_out,
   output wire evt_irq_out
);
   reg [7:0] latch;
   reg [7:0] pin_direction_mask;
   reg [7:0] option_config;
   reg [7:0] irq_control;
   reg [1:0] evt_status;
   reg [1:0] evt_enable;
   reg [31:0] rdata;
   reg slverr;
   reg [7:0] next_rd;
   reg next_hit;
   wire mismatch;
   wire pullup_off_n;
   wire [9:0] idx;
   wire acc;
   wire wr;
   wire port_hit;
   wire irq_hit;
   wire [1:0] evt_set;
   // Access phase of a zero-wait transfer; word index from byte address
   assign acc = psel_in & penable_in;
   assign wr = acc & pwrite_in & pstrb_in[0];
   assign idx = paddr_in[11:2];
   assign port_hit = (idx == {2'h0, `IDX_KEYPAD_PORT});
   assign irq_hit = (idx == {2'h0, `IDX_IRQ_CONTROL});
   assign pready_out = 1'b1;
   assign prdata_out = rdata;
   assign pslverr_out = acc & ~next_hit;
   assign pullup_off_n = option_config[`BIT_PULLUP_OFF_N];
   // Any port read or write refreshes reference
   change_detect u_cd (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pins_in(pin_in[7:4]),
      .dir_in(pin_direction_mask[7:4]),
      .refresh_in(acc & port_hit),
      .mismatch_out(mismatch)
   );
   // Register writes; set of change flag beats software clear
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         latch <= `RST_LATCH;
         pin_direction_mask <= `RST_PIN_DIRECTION;
         option_config <= `RST_OPTION_CONFIG;
         irq_control <= `RST_IRQ_CONTROL;
      end else begin
         if (wr && port_hit) begin
            latch <= pwdata_in[7:0];
         end
         if (wr && idx == {2'h0, `IDX_PIN_DIRECTION}) begin
            pin_direction_mask <= pwdata_in[7:0];
         end
         if (wr && idx == {2'h0, `IDX_OPTION_CONFIG}) begin
            option_config <= pwdata_in[7:0];
         end
         if (wr && irq_hit) begin
            irq_control <= pwdata_in[7:0];
         end
         if (mismatch) begin
            irq_control[`BIT_CHANGE_FLAG] <= 1'b1;
         end
      end
   end
   // Pin drivers and pull-ups, registered so outputs come from flops
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_out <= 8'h00;
         pin_oe_n_out <= 8'hFF;
         pullup_en_out <= 8'h00;
      end else begin
         pin_out <= latch;
         pin_oe_n_out <= pin_direction_mask;
         pullup_en_out <= pin_direction_mask & {8{~pullup_off_n}};
      end
   end
   assign change_irq_out = irq_control[`BIT_CHANGE_FLAG] &
      irq_control[`BIT_CHANGE_IRQ_EN] & irq_control[`BIT_GLOBAL_IRQ_EN];
   // Wake request ignores global enable, so sleep exits on a key
   assign wake_out = irq_control[`BIT_CHANGE_FLAG] & irq_control[`BIT_CHANGE_IRQ_EN];
   // Sticky events: bit0 port change, bit1 bus error
   assign evt_set = {pslverr_out, mismatch};
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         evt_status <= 2'h0;
         evt_enable <= `RST_EVT_ENABLE;
      end else begin
         if (wr && idx == {2'h0, `IDX_EVT_ENABLE}) begin
            evt_enable <= pwdata_in[1:0];
         end
         if (wr && idx == {2'h0, `IDX_EVT_CLEAR}) begin
            evt_status <= (evt_status & ~pwdata_in[1:0]) | evt_set;
         end else begin
            evt_status <= evt_status | evt_set;
         end
      end
   end
   assign evt_irq_out = |(evt_status & evt_enable);
   // Read mux; clear register is write-only and reads zero
   always @* begin
      next_rd = 8'h00;
      next_hit = 1'b1;
      case (idx)
         {2'h0, `IDX_KEYPAD_PORT}: next_rd = pin_in;
         {2'h0, `IDX_IRQ_CONTROL}: next_rd = irq_control;
         {2'h0, `IDX_OPTION_CONFIG}: next_rd = option_config;
         {2'h0, `IDX_PIN_DIRECTION}: next_rd = pin_direction_mask;
         {2'h0, `IDX_EVT_STATUS}: next_rd = {6'h00, evt_status};
         {2'h0, `IDX_EVT_CLEAR}: next_rd = 8'h00;
         {2'h0, `IDX_EVT_ENABLE}: next_rd = {6'h00, evt_enable};
         default: next_hit = 1'b0;
      endcase
   end
   // Read data taken in setup so it is stable during the access phase
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata <= 32'h0;
         slverr <= 1'b0;
      end else if (psel_in && !penable_in) begin
         rdata <= {24'h0, next_rd};
         slverr <= ~next_hit;
      end
   end
endmodule
`default_nettype wire

// File: hw/keypad_port_consts.vh
// Purpose: constants for the keypad port with change interrupt
// Assumes: APB byte addresses, 32-bit data, registers in low 8 bits
// Notes: definitions only
`ifndef KEYPAD_PORT_CONSTS_VH
`define KEYPAD_PORT_CONSTS_VH
// Register indices as printed; byte address is four times the index
`define IDX_KEYPAD_PORT 8'h06
`define IDX_IRQ_CONTROL 8'h0B
`define IDX_OPTION_CONFIG 8'h81
`define IDX_PIN_DIRECTION 8'h86
`define IDX_EVT_STATUS 8'hC0
`define IDX_EVT_CLEAR 8'hC1
`define IDX_EVT_ENABLE 8'hC2
// Field positions
`define BIT_CHANGE_FLAG 0
`define BIT_CHANGE_IRQ_EN 3
`define BIT_GLOBAL_IRQ_EN 7
`define BIT_PULLUP_OFF_N 7
// Reset values
`define RST_IRQ_CONTROL 8'h00
`define RST_OPTION_CONFIG 8'hFF
`define RST_PIN_DIRECTION 8'hFF
`define RST_LATCH 8'h00
`define RST_EVT_ENABLE 2'h0
`endif

// File: test/keypad_model.sv
// Purpose: keypad on the port pins
// Assumes: a pressed key shorts its pin to ground unless the port drives that pin
// Notes: an undriven pin without pull-up shows the inverse of the latch
`timescale 1ns/1ns
`default_nettype none
module keypad_model (
   input wire logic [7:0] pin_out, pin_oe_n_out, pullup_en_out, key_down,
   output logic [7:0] pin_in
);
   // released pin floats
   // Floating level is not held so a stale value cannot pass for a pull-up
   assign pin_in = (~pin_oe_n_out & pin_out)
      | (pin_oe_n_out & ~key_down & (pullup_en_out | ~pin_out));
endmodule
`default_nettype wire

// File: test/keypad_port_assertions.sv
// Purpose: port and bus assertions for the keypad port
// Assumes: zero-wait bus, outputs one cycle behind their registers
// Notes: bound to every keypad_port instance
`timescale 1ns/1ns
`default_nettype none
module keypad_port_chk (
   input wire logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in,
   input wire logic [31:0] paddr_in, pwdata_in, prdata_out,
   input wire logic [3:0] pstrb_in,
   input wire logic pready_out, pslverr_out, change_irq_out, wake_out, evt_irq_out,
   input wire logic [7:0] pin_in, pin_out, pin_oe_n_out, pullup_en_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Write strobe as the slave takes it
   wire logic wr = psel_in && penable_in && pwrite_in && pstrb_in[0];
   AST_READY: assert property (pready_out) else $error("ready low");
   AST_ERR_PHASE: assert property (pslverr_out |-> psel_in && penable_in)
      else $error("error outside access");
   AST_UNMAPPED: assert property (psel_in && penable_in && paddr_in == 32'h100
      |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped not refused");
   AST_NO_PULL_OUT: assert property ((pullup_en_out & ~pin_oe_n_out) == 8'h00)
      else $error("pull-up on driven pin");
   AST_IRQ_GATE: assert property (change_irq_out |-> wake_out)
      else $error("irq without change enable");
   AST_LATCH_WR: assert property (wr && paddr_in == 32'h18
      |-> ##2 pin_out == $past(pwdata_in[7:0], 2)) else $error("latch not driven");
   AST_DIR_WR: assert property (wr && paddr_in == 32'h218
      |-> ##2 pin_oe_n_out == $past(pwdata_in[7:0], 2)) else $error("direction lost");
   AST_RST_DIR: assert property ($fell(sys_rst_in) |-> pin_oe_n_out == 8'hFF)
      else $error("pins not inputs after reset");
   AST_RST_PULL: assert property ($fell(sys_rst_in) |-> pullup_en_out == 8'h00)
      else $error("pull-ups on after reset");
endmodule
bind keypad_port keypad_port_chk keypad_port_chk_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pstrb_in(pstrb_in), .pin_in(pin_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .change_irq_out(change_irq_out),
   .wake_out(wake_out), .evt_irq_out(evt_irq_out), .pin_out(pin_out),
   .pin_oe_n_out(pin_oe_n_out), .pullup_en_out(pullup_en_out));
`default_nettype wire

// File: test/tb_top.sv
// Purpose: register and pin tests of the keypad port
// Assumes: zero-wait bus, pins settle three cycles after a write
// Notes: port is polled only where change detection is not relied on
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
   $display("mismatch at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top;
   logic clk_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, change_irq, wake, evt_irq;
   logic [31:0] paddr = 0, pwdata = 0, prdata, r;
   logic [7:0] key_down = 0, pin_in, pin_out, pin_oe_n, pullup_en;
   int errors = 0, n_tests = 0, cyc = 0;
   keypad_port keypad_port_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n), .pullup_en_out(pullup_en),
      .change_irq_out(change_irq), .wake_out(wake), .evt_irq_out(evt_irq));
   keypad_model keypad_model_i (.pin_out(pin_out), .pin_oe_n_out(pin_oe_n),
      .pullup_en_out(pullup_en), .key_down(key_down), .pin_in(pin_in));
   initial forever #5 clk_in = ~clk_in;
   task complete_run;
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One bus transfer; request held until ready is seen
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_in);
      penable <= 1;
      do @(posedge clk_in); while (pready !== 1'b1);
      r = prdata;
      psel <= 0; penable <= 0;
   endtask
   // Pins and pull-ups trail the registers by a cycle
   task settle;
      repeat (3) @(posedge clk_in);
      #1;
   endtask
   // Hang guard, the run needs under a hundred cycles
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 0;
      apb(0, 32'h218, 0); `CHK(r[7:0], 8'hFF)
      apb(0, 32'h204, 0); `CHK(r[7:0], 8'hFF)
      apb(1, 32'h204, 32'h7F);
      apb(1, 32'h218, 32'hCF);
      apb(1, 32'h18, 32'hA5);
      settle; `CHK({pin_oe_n, pullup_en, pin_out}, 24'hCFCFA5)
      apb(0, 32'h18, 0); `CHK(r, 32'hEF)
      // no polling while the change check is relied on
      apb(1, 32'h2C, 32'h88);
      @(posedge clk_in) key_down <= 8'h01;
      settle; `CHK(change_irq, 1'b0)
      @(posedge clk_in) key_down <= 8'h41;
      settle; `CHK(change_irq, 1'b1)
      apb(1, 32'h2C, 32'h88); settle; `CHK(change_irq, 1'b1)
      apb(0, 32'h18, 0); `CHK(r, 32'hAE)
      apb(1, 32'h2C, 32'h88); settle; `CHK(change_irq, 1'b0)
      @(posedge clk_in) key_down <= 8'h01;
      apb(1, 32'h2C, 32'h08); settle; `CHK({change_irq, wake}, 2'b01)
      apb(1, 32'h308, 32'h2); apb(0, 32'h100, 0); `CHK(r, 32'h0)
      settle; `CHK(evt_irq, 1'b1)
      apb(0, 32'h300, 0); `CHK(r[1], 1'b1)
      `CHK(r[0], 1'b1)
      apb(1, 32'h304, 32'h2);
      apb(1, 32'h308, 32'h0);
      apb(0, 32'h100, 0);
      settle; `CHK(evt_irq, 1'b0)
      complete_run();
   end
endmodule
`default_nettype wire
